/* dv/remote_status_reporting_bench.sv */
`timescale 1ns/1ps

module remote_status_reporting_bench;
  import rss_pkg::*;

  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [4:0] pls = 5'h00;
  logic [15:0] oc = 16'h0000;
  logic [15:0] qc = 16'h0000;
  logic cal = 1'b0;
  logic setl = 1'b0;
  logic mav = 1'b0;
  logic eq = 1'b0;
  logic pend = 1'b0;
  logic cv;
  rss_cmd_t cc;
  logic [15:0] cd;
  logic rv;
  logic [15:0] rdat;
  logic [7:0] stb;
  logic [7:0] ses;
  int error_cnt = 0;
  int cmp_count = 0;
  logic ok;
  logic [7:0] ebit [4] = '{8'h20, 8'h10, 8'h08, 8'h04};

  always #2.5 mclk_i = ~mclk_i;

  rss_status u_rss_status (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cv), .cmd_code_i(cc),
    .cmd_data_i(cd), .oper_cond_i(oc), .calibrating_i(cal), .settling_i(setl),
    .ques_cond_i(qc), .param_ignored_i(pls[4]), .msg_avail_i(mav),
    .err_queue_nonempty_i(eq), .syntax_err_i(pls[0]), .exec_err_i(pls[1]),
    .device_err_i(pls[2]), .query_req_i(pls[3]), .ops_pending_i(pend),
    .resp_valid_o(rv), .resp_data_o(rdat), .status_byte_o(stb),
    .standard_event_status_o(ses)
  );

  rss_ctrl_model u_rss_ctrl_model (
    .mclk_i(mclk_i), .resp_valid_i(rv), .resp_data_i(rdat),
    .cmd_valid_o(cv), .cmd_code_o(cc), .cmd_data_o(cd)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rd(input rss_cmd_t c, input logic [15:0] e);
    logic [15:0] r;
    u_rss_ctrl_model.issue(c, 16'h0000, r);
    chk(r, e);
  endtask

  task automatic wr(input rss_cmd_t c, input logic [15:0] d);
    logic [15:0] r;
    u_rss_ctrl_model.issue(c, d, r);
  endtask

  task automatic pulse(input int k);
    pls[k] = 1'b1;
    cyc(1);
    pls[k] = 1'b0;
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    cyc(10);
    arst_n_i = 1'b1;
    cyc(2);
    chk({8'h00, ses}, 16'h0080);
    chk({8'h00, stb}, 16'h0000);
    rd(RSS_CMD_RD_ESR, 16'h0080);
    // syntax, execution, device and query error in turn
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      cyc(1);
      chk({8'h00, ses}, {8'h00, ebit[k]});
      rd(RSS_CMD_RD_ESR, {8'h00, ebit[k]});
    end
    wr(RSS_CMD_WR_ESE, 16'h00ff);
    rd(RSS_CMD_RD_ESE, 16'h00bd);
    wr(RSS_CMD_WR_SRE, 16'h00ff);
    rd(RSS_CMD_RD_SRE, 16'h00bf);
    pulse(1);
    cyc(3);
    chk({8'h00, stb}, 16'h0060);
    rd(RSS_CMD_RD_ESR, 16'h0010);
    cyc(3);
    chk({8'h00, stb}, 16'h0000);
    mav = 1'b1;
    eq = 1'b1;
    cyc(3);
    chk({8'h00, stb}, 16'h0054);
    rd(RSS_CMD_RD_STB, 16'h0054);
    pulse(3);
    cyc(1);
    chk({8'h00, ses}, 16'h0000);
    mav = 1'b0;
    eq = 1'b0;
    pend = 1'b1;
    wr(RSS_CMD_OPC, 16'h0000);
    cyc(3);
    chk({8'h00, ses}, 16'h0000);
    pend = 1'b0;
    cyc(2);
    chk({8'h00, ses}, 16'h0001);
    rd(RSS_CMD_RD_ESR, 16'h0001);
    // nothing pending: the bit follows right after the command
    wr(RSS_CMD_OPC, 16'h0000);
    chk({8'h00, ses}, 16'h0001);
    rd(RSS_CMD_RD_ESR, 16'h0001);
    cal = 1'b1;
    setl = 1'b1;
    oc = 16'h0010;
    cyc(4);
    rd(RSS_CMD_RD_OPER_COND, 16'h0013);
    rd(RSS_CMD_RD_OPER_COND, 16'h0013);
    wr(RSS_CMD_WR_OPER_EN, 16'h0001);
    rd(RSS_CMD_RD_OPER_EN, 16'h0001);
    cyc(3);
    chk({8'h00, stb & 8'hc0}, 16'h00c0);
    rd(RSS_CMD_RD_OPER_EV, 16'h0013);
    rd(RSS_CMD_RD_OPER_EV, 16'h0000);
    cyc(3);
    chk({8'h00, stb & 8'h80}, 16'h0000);
    fork
      begin
        cyc(6);
        cal = 1'b0;
      end
      u_rss_ctrl_model.wait_idle(ok);
    join
    chk({15'h0000, ok}, 16'h0001);
    pulse(4);
    qc = 16'h0001;
    cyc(3);
    rd(RSS_CMD_RD_QUES_COND, 16'h0001);
    rd(RSS_CMD_RD_QUES_COND, 16'h0001);
    rd(RSS_CMD_RD_QUES_EV, 16'h4001);
    rd(RSS_CMD_RD_QUES_EV, 16'h0000);
    wr(RSS_CMD_WR_QUES_EN, 16'h4000);
    pulse(4);
    cyc(4);
    chk({8'h00, stb & 8'h08}, 16'h0008);
    // clear status drops latched events and a waiting operation-complete
    pulse(0);
    pend = 1'b1;
    wr(RSS_CMD_OPC, 16'h0000);
    wr(RSS_CMD_CLS, 16'h0000);
    pend = 1'b0;
    cyc(2);
    rd(RSS_CMD_RD_ESR, 16'h0000);
    rd(RSS_CMD_RD_QUES_EV, 16'h0000);
    cyc(2);
    chk({8'h00, stb & 8'h28}, 16'h0000);
    complete_run();
  end

  initial begin
    #20000;
    error_cnt++;
    complete_run();
  end
endmodule

/* dv/rss_ctrl_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// remote controller issuing status commands
// ----------------------------------------
module rss_ctrl_model
  import rss_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resp_valid_i,
  input wire logic [15:0] resp_data_i,
  output logic cmd_valid_o,
  output rss_cmd_t cmd_code_o,
  output logic [15:0] cmd_data_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = RSS_CMD_NONE;
    cmd_data_o = 16'h0000;
  end

  task automatic issue(input rss_cmd_t c, input logic [15:0] d, output logic [15:0] r);
    int n;
    r = 16'hxxxx;
    @(negedge mclk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = c;
    cmd_data_o = d;
    @(negedge mclk_i);
    cmd_valid_o = 1'b0;
    cmd_code_o = RSS_CMD_NONE;
    // released data shows garbage, not the last value
    cmd_data_o = ~d;
    n = 0;
    while (n < 4 && resp_valid_i !== 1'b1) begin
      @(negedge mclk_i);
      n++;
    end
    if (resp_valid_i === 1'b1) begin
      r = resp_data_i;
    end
  endtask

  // adjustment counts as done only once condition bit 0 reads low
  task automatic wait_idle(output logic ok);
    logic [15:0] r;
    ok = 1'b0;
    for (int i = 0; i < 12 && !ok; i++) begin
      issue(RSS_CMD_RD_OPER_COND, 16'h0000, r);
      ok = (r[0] === 1'b0);
    end
  endtask
endmodule

/* rtl/rss_event_group.sv */
`timescale 1ns/1ps
`include "rss_regs.svh"

module rss_event_group
  import rss_pkg::*;
#(
  parameter logic [15:0] VALID_MASK = 16'hffff
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [15:0] cond_i,
  input wire logic [15:0] set_i,
  input wire logic rd_clr_i,
  input wire logic clr_i,
  input wire logic en_wr_i,
  input wire logic [15:0] en_data_i,
  output logic [15:0] cond_o,
  output logic [15:0] event_o,
  output logic [15:0] enable_o,
  output logic summary_o
);

  logic [15:0] rise;
  logic [15:0] next_event;

  // ----------------------------------------
  // condition, event latch, enable
  // ----------------------------------------
  assign rise = ((cond_i & ~cond_o) | set_i) & VALID_MASK;

  always_comb begin
    next_event = event_o;
    if (rd_clr_i || clr_i) begin
      next_event = `RSS_REG_RESET;
    end
    // a rising event in the clearing cycle is kept
    next_event = next_event | rise;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cond_o <= `RSS_REG_RESET;
    end else begin
      cond_o <= cond_i & VALID_MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      event_o <= `RSS_REG_RESET;
    end else begin
      event_o <= next_event;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable_o <= `RSS_REG_RESET;
    end else if (en_wr_i) begin
      enable_o <= en_data_i & VALID_MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      summary_o <= 1'b0;
    end else begin
      summary_o <= rss_any_enabled(event_o, enable_o);
    end
  end

  ev_clear_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    rd_clr_i |=> ((event_o & ~$past(rise)) == `RSS_REG_RESET))
    else $error("event register not cleared after query");

  ev_keep_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (!rd_clr_i && !clr_i) |=> ((event_o & $past(event_o)) == $past(event_o)))
    else $error("event bit lost without a clear");

endmodule

/* rtl/rss_pkg.sv */
package rss_pkg;

  typedef enum logic [3:0] {
    RSS_CMD_NONE = 4'h0,
    RSS_CMD_RD_STB = 4'h1,
    RSS_CMD_RD_SRE = 4'h2,
    RSS_CMD_WR_SRE = 4'h3,
    RSS_CMD_RD_ESR = 4'h4,
    RSS_CMD_RD_ESE = 4'h5,
    RSS_CMD_WR_ESE = 4'h6,
    RSS_CMD_CLS = 4'h7,
    RSS_CMD_OPC = 4'h8,
    RSS_CMD_RD_OPER_EV = 4'h9,
    RSS_CMD_RD_OPER_COND = 4'ha,
    RSS_CMD_WR_OPER_EN = 4'hb,
    RSS_CMD_RD_QUES_EV = 4'hc,
    RSS_CMD_RD_QUES_COND = 4'hd,
    RSS_CMD_WR_QUES_EN = 4'he,
    RSS_CMD_RD_OPER_EN = 4'hf
  } rss_cmd_t;

  // summary of a register gated by its enable mask
  function automatic logic rss_any_enabled(input logic [15:0] bits, input logic [15:0] en);
    rss_any_enabled = |(bits & en);
  endfunction

endpackage

/* rtl/rss_regs.svh */
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// ----------------------------------------
// status byte bit positions
// ----------------------------------------
`define RSS_STB_OPER 7
`define RSS_STB_RQS 6
`define RSS_STB_ESB 5
`define RSS_STB_MAV 4
`define RSS_STB_QUES 3
`define RSS_STB_EQ 2
`define RSS_SRE_MASK 8'hbf

// ----------------------------------------
// standard event status bit positions
// ----------------------------------------
`define RSS_ESR_PON 7
`define RSS_ESR_CME 5
`define RSS_ESR_EXE 4
`define RSS_ESR_DDE 3
`define RSS_ESR_QYE 2
`define RSS_ESR_OPC 0
`define RSS_ESR_RESET 8'h80
`define RSS_ESR_MASK 8'hbd

// ----------------------------------------
// condition group layouts
// ----------------------------------------
`define RSS_OPER_CAL 0
`define RSS_OPER_SETTLE 1
`define RSS_OPER_MASK 16'h4313
`define RSS_QUES_CMDWARN 14
`define RSS_QUES_MASK 16'h418d
`define RSS_REG_RESET 16'h0000
`define RSS_BYTE_RESET 8'h00

`endif

/* rtl/rss_status.sv */
`timescale 1ns/1ps
`include "rss_regs.svh"


module rss_status
  import rss_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire rss_cmd_t cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic [15:0] oper_cond_i,
  input wire logic calibrating_i,
  input wire logic settling_i,
  input wire logic [15:0] ques_cond_i,
  input wire logic param_ignored_i,
  input wire logic msg_avail_i,
  input wire logic err_queue_nonempty_i,
  input wire logic syntax_err_i,
  input wire logic exec_err_i,
  input wire logic device_err_i,
  input wire logic query_req_i,
  input wire logic ops_pending_i,
  output logic resp_valid_o,
  output logic [15:0] resp_data_o,
  output logic [7:0] status_byte_o,
  output logic [7:0] standard_event_status_o
);

  logic [7:0] service_request_enable;
  logic [7:0] standard_event_enable;
  logic [7:0] next_esr;
  logic [7:0] stb_low;
  logic [15:0] oper_cond_all;
  logic [15:0] ques_set;
  logic [15:0] oper_cond;
  logic [15:0] oper_event;
  logic [15:0] oper_enable;
  logic [15:0] ques_cond;
  logic [15:0] ques_event;
  logic [15:0] ques_enable;
  logic oper_summary;
  logic ques_summary;
  logic opc_armed;
  logic rqs;
  logic is_cmd_rd_esr;
  logic is_cmd_cls;

  assign is_cmd_rd_esr = cmd_valid_i && (cmd_code_i == RSS_CMD_RD_ESR);
  assign is_cmd_cls = cmd_valid_i && (cmd_code_i == RSS_CMD_CLS);

  // ----------------------------------------
  // operation and questionable groups
  // ----------------------------------------
  always_comb begin
    oper_cond_all = oper_cond_i;
    oper_cond_all[`RSS_OPER_CAL] = calibrating_i;
    oper_cond_all[`RSS_OPER_SETTLE] = settling_i;
    ques_set = `RSS_REG_RESET;
    ques_set[`RSS_QUES_CMDWARN] = param_ignored_i;
  end

  rss_event_group #(
    .VALID_MASK(`RSS_OPER_MASK)
  ) u_oper (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cond_i(oper_cond_all),
    .set_i(`RSS_REG_RESET),
    .rd_clr_i(cmd_valid_i && (cmd_code_i == RSS_CMD_RD_OPER_EV)),
    .clr_i(is_cmd_cls),
    .en_wr_i(cmd_valid_i && (cmd_code_i == RSS_CMD_WR_OPER_EN)),
    .en_data_i(cmd_data_i),
    .cond_o(oper_cond),
    .event_o(oper_event),
    .enable_o(oper_enable),
    .summary_o(oper_summary)
  );

  // command warning is a one-shot event with no lasting condition
  rss_event_group #(
    .VALID_MASK(`RSS_QUES_MASK)
  ) u_ques (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cond_i(ques_cond_i),
    .set_i(ques_set),
    .rd_clr_i(cmd_valid_i && (cmd_code_i == RSS_CMD_RD_QUES_EV)),
    .clr_i(is_cmd_cls),
    .en_wr_i(cmd_valid_i && (cmd_code_i == RSS_CMD_WR_QUES_EN)),
    .en_data_i(cmd_data_i),
    .cond_o(ques_cond),
    .event_o(ques_event),
    .enable_o(ques_enable),
    .summary_o(ques_summary)
  );

  // ----------------------------------------
  // enable registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      service_request_enable <= `RSS_BYTE_RESET;
    end else if (cmd_valid_i && (cmd_code_i == RSS_CMD_WR_SRE)) begin
      service_request_enable <= cmd_data_i[7:0] & `RSS_SRE_MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      standard_event_enable <= `RSS_BYTE_RESET;
    end else if (cmd_valid_i && (cmd_code_i == RSS_CMD_WR_ESE)) begin
      standard_event_enable <= cmd_data_i[7:0] & `RSS_ESR_MASK;
    end
  end

  // ----------------------------------------
  // standard event status
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opc_armed <= 1'b0;
    end else if (cmd_valid_i && (cmd_code_i == RSS_CMD_OPC)) begin
      opc_armed <= 1'b1;
    end else if (is_cmd_cls || (opc_armed && !ops_pending_i)) begin
      opc_armed <= 1'b0;
    end
  end

  always_comb begin
    next_esr = standard_event_status_o;
    if (is_cmd_rd_esr || is_cmd_cls) begin
      next_esr = `RSS_BYTE_RESET;
    end
    // sets win over the read or clear in the same cycle
    if (syntax_err_i) begin
      next_esr[`RSS_ESR_CME] = 1'b1;
    end
    if (exec_err_i) begin
      next_esr[`RSS_ESR_EXE] = 1'b1;
    end
    if (device_err_i) begin
      next_esr[`RSS_ESR_DDE] = 1'b1;
    end
    if (query_req_i && !msg_avail_i) begin
      next_esr[`RSS_ESR_QYE] = 1'b1;
    end
    if (opc_armed && !ops_pending_i) begin
      next_esr[`RSS_ESR_OPC] = 1'b1;
    end
    next_esr = next_esr & `RSS_ESR_MASK;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      standard_event_status_o <= `RSS_ESR_RESET;
    end else begin
      standard_event_status_o <= next_esr;
    end
  end

  // ----------------------------------------
  // status byte
  // ----------------------------------------
  always_comb begin
    stb_low = `RSS_BYTE_RESET;
    stb_low[`RSS_STB_OPER] = oper_summary;
    stb_low[`RSS_STB_ESB] = rss_any_enabled({8'h00, standard_event_status_o},
      {8'h00, standard_event_enable});
    stb_low[`RSS_STB_MAV] = msg_avail_i;
    stb_low[`RSS_STB_QUES] = ques_summary;
    stb_low[`RSS_STB_EQ] = err_queue_nonempty_i;
    rqs = rss_any_enabled({8'h00, stb_low}, {8'h00, service_request_enable});
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_byte_o <= `RSS_BYTE_RESET;
    end else begin
      status_byte_o <= stb_low | ({7'h00, rqs} << `RSS_STB_RQS);
    end
  end

  // ----------------------------------------
  // query responses
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_data_o <= `RSS_REG_RESET;
    end else begin
      resp_valid_o <= 1'b0;
      if (cmd_valid_i) begin
        resp_valid_o <= 1'b1;
        case (cmd_code_i)
          RSS_CMD_RD_STB: resp_data_o <= {8'h00, status_byte_o};
          RSS_CMD_RD_SRE: resp_data_o <= {8'h00, service_request_enable};
          RSS_CMD_RD_ESR: resp_data_o <= {8'h00, standard_event_status_o};
          RSS_CMD_RD_ESE: resp_data_o <= {8'h00, standard_event_enable};
          RSS_CMD_RD_OPER_EV: resp_data_o <= oper_event;
          RSS_CMD_RD_OPER_COND: resp_data_o <= oper_cond;
          RSS_CMD_RD_OPER_EN: resp_data_o <= oper_enable;
          RSS_CMD_RD_QUES_EV: resp_data_o <= ques_event;
          RSS_CMD_RD_QUES_COND: resp_data_o <= ques_cond;
          default: resp_valid_o <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic powered;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      powered <= 1'b0;
    end else begin
      powered <= 1'b1;
    end
  end

  sequence opc_request;
    cmd_valid_i && (cmd_code_i == RSS_CMD_OPC);
  endsequence

  sequence ops_finished;
    !ops_pending_i;
  endsequence

  pwr_on_bit_a: assert property (!powered |-> standard_event_status_o[`RSS_ESR_PON])
    else $error("power-on bit missing after reset");
  opc_done_a: assert property (opc_request ##1 ops_finished |=>
    standard_event_status_o[`RSS_ESR_OPC])
    else $error("operation complete bit not set");
  syntax_err_a: assert property (syntax_err_i |=> standard_event_status_o[`RSS_ESR_CME])
    else $error("command error bit not set");
  exec_err_a: assert property (exec_err_i |=> standard_event_status_o[`RSS_ESR_EXE])
    else $error("execution error bit not set");
  dev_err_a: assert property (device_err_i |=> standard_event_status_o[`RSS_ESR_DDE])
    else $error("device error bit not set");
  query_err_a: assert property ((query_req_i && !msg_avail_i) |=>
    standard_event_status_o[`RSS_ESR_QYE])
    else $error("query error bit not set");
  mav_follow_a: assert property (status_byte_o[`RSS_STB_MAV] == $past(msg_avail_i))
    else $error("message available not following");
  queue_bit_a: assert property (status_byte_o[`RSS_STB_EQ] == $past(err_queue_nonempty_i))
    else $error("queue bit not following");
  reserved_zero_a: assert property (status_byte_o[1:0] == 2'h0 &&
    standard_event_status_o[6] == 1'b0 && standard_event_status_o[1] == 1'b0)
    else $error("reserved bit nonzero");
  srq_cause_a: assert property (status_byte_o[`RSS_STB_RQS] |->
    |(status_byte_o & $past(service_request_enable) & `RSS_SRE_MASK))
    else $error("service request without enabled cause");
  oper_sum_a: assert property ((|(oper_event & oper_enable)) |=> ##1
    status_byte_o[`RSS_STB_OPER])
    else $error("operation summary missing");
  ques_sum_a: assert property ((|(ques_event & ques_enable)) |=> ##1
    status_byte_o[`RSS_STB_QUES])
    else $error("questionable summary missing");
  esb_sum_a: assert property ((|(standard_event_status_o & standard_event_enable)) |=>
    status_byte_o[`RSS_STB_ESB])
    else $error("event summary bit missing");
  cond_query_a: assert property ((cmd_valid_i && cmd_code_i == RSS_CMD_RD_OPER_COND) |=>
    resp_valid_o && resp_data_o == $past(oper_cond))
    else $error("condition query wrong");
  cal_cond_a: assert property (oper_cond[`RSS_OPER_CAL] == $past(calibrating_i))
    else $error("calibrating condition not following");
  settle_cond_a: assert property (oper_cond[`RSS_OPER_SETTLE] == $past(settling_i))
    else $error("settling condition not following");
  cmd_warn_a: assert property (param_ignored_i |=> ques_event[`RSS_QUES_CMDWARN])
    else $error("command warning event not latched");

endmodule
